// [logic/amu_math_unit.v]
/*
 Accumulator math unit: BCD double divide, real divide, BCD increment
 and decrement of a memory word, 16-bit binary add, with status flags.
 Assumes the instruction sequencer fetches operands, resolves pointers
 (ptr_valid) and writes mem_wdata back to the addressed word.
*/
// Functional notes
// - BCD divide: accumulator by two-word divisor
// - BCD divide refuses a constant divisor
// - Quotient to accumulator, remainder to stack
// - Unusable divisor raises operand-too-large flag
// - Zero flag follows accumulator or memory-word result
// - Negative flag on negative result
// - Bad BCD digit raises illegal-digit flag
// - Flags hold until next updating op
// - Real divide, quotient back to accumulator
// - Invalid pointer raises bad-pointer flag
// - Validity flag reports accumulator float state
// - Real divide underflow raises underflow flag
// - Non-real operand raises illegal-digit flag
// - Wrong sign bit raises signed-overflow flag
// - Increment adds one to BCD word
// - Decrement subtracts one from BCD word
// - Binary add of 16-bit operand
// - Sum fills full 32-bit accumulator
// - Separate 16-bit and 32-bit carry flags
// - Underflow flag is the shared one
`timescale 1ns/1ns
`include "amu_defs.vh"

module amu_math_unit (
    input wire core_clk,
    input wire rst,
    input wire op_start,
    input wire [2:0] op_code,
    input wire [1:0] op_src,
    input wire [15:0] opnd_lo,
    input wire [15:0] opnd_hi,
    input wire ptr_valid,
    input wire acc_load,
    input wire [31:0] acc_load_val,
    output reg busy_q,
    output reg done_q,
    output reg src_rejected_q,
    output reg [31:0] acc_q,
    output reg [31:0] stack1_q,
    output reg [15:0] mem_wdata_q,
    output reg mem_we_q,
    output reg operand_too_large_flag,
    output reg zero_result_flag,
    output reg negative_result_flag,
    output reg bad_pointer_flag,
    output reg float_validity_flag,
    output reg signed_overflow_flag,
    output reg float_underflow_flag,
    output reg illegal_digit_flag,
    output reg carry16_flag,
    output reg carry32_flag
);
localparam DW = `AMU_DIV_W;
// ----------------------------------------------------------------
// Number-format helpers
// ----------------------------------------------------------------
function bcd_ok;
    input [31:0] v;
    integer i;
    begin
        bcd_ok = 1'b1;
        for (i = 0; i < 8; i = i + 1) begin
            if (v[4*i+3] && (v[4*i+2] || v[4*i+1]))
                bcd_ok = 1'b0;
        end
    end
endfunction
function [31:0] bcd_to_bin;
    input [31:0] v;
    integer i;
    begin
        bcd_to_bin = 32'h00000000;
        for (i = 7; i >= 0; i = i - 1)
            bcd_to_bin = (bcd_to_bin << 3) + (bcd_to_bin << 1) + {28'h0000000, v[4*i+:4]};
    end
endfunction
// Double dabble; inputs above 99999999 are never offered
function [31:0] bin_to_bcd;
    input [31:0] v;
    integer i;
    integer k;
    reg [31:0] r;
    begin
        r = 32'h00000000;
        for (i = 31; i >= 0; i = i - 1) begin
            for (k = 0; k < 8; k = k + 1) begin
                if (r[4*k+:4] > 4'h4)
                    r[4*k+:4] = r[4*k+:4] + 4'h3;
            end
            r = {r[30:0], v[i]};
        end
        bin_to_bcd = r;
    end
endfunction
// NaN and infinity are not usable reals
function non_real;
    input [31:0] f;
    begin
        non_real = (f[30:23] == `AMU_FLT_EXP_ALL);
    end
endfunction

// ----------------------------------------------------------------
// Operand decode
// ----------------------------------------------------------------
wire [31:0] pair = {opnd_hi, opnd_lo};
wire ptr_bad = (op_src == `AMU_SRC_PTR) && !ptr_valid;
wire accept = op_start && !busy_q;
wire [31:0] acc_bin = bcd_to_bin(acc_q);
wire [31:0] dsr_bin = bcd_to_bin(pair);
wire [31:0] word_bin = bcd_to_bin({16'h0000, opnd_lo});
wire [31:0] inc_bin = (word_bin == `AMU_WORD_MAX_BIN) ? 32'h00000000 : word_bin + 32'h00000001;
wire [31:0] dec_bin = (word_bin == 32'h00000000) ? `AMU_WORD_MAX_BIN : word_bin - 32'h00000001;
wire [31:0] inc_bcd = bin_to_bcd(inc_bin);
wire [31:0] dec_bcd = bin_to_bcd(dec_bin);
wire [32:0] sum33 = {1'b0, acc_q} + {17'h0, opnd_lo};
wire [16:0] sum17 = {1'b0, acc_q[15:0]} + {1'b0, opnd_lo};
// Denormals are flushed to zero; this unit does not keep gradual underflow
wire a_zero = (acc_q[30:23] == 8'h00);
wire b_zero = (pair[30:23] == 8'h00);
wire [23:0] man_a = {1'b1, acc_q[22:0]};
wire [23:0] man_b = {1'b1, pair[22:0]};
wire sign_ab = acc_q[31] ^ pair[31];
wire [9:0] ebase = {2'b00, acc_q[30:23]} - {2'b00, pair[30:23]} + `AMU_FLT_BIAS_M1;

// ----------------------------------------------------------------
// Shared divider
// ----------------------------------------------------------------
reg state_q;
reg mode_q;
reg sign_q;
reg [9:0] ebase_q;
reg div_go;
reg [DW-1:0] div_a;
reg [DW-1:0] div_b;
wire div_done;
wire [DW-1:0] div_q;
wire [DW-1:0] div_r;
amu_seq_divider #(
    .W(DW)
) u_div (
    .core_clk(core_clk),
    .rst(rst),
    .start(div_go),
    .dividend(div_a),
    .divisor(div_b),
    .busy(),
    .done(div_done),
    .quotient(div_q),
    .remainder(div_r)
);
always @* begin
    div_go = 1'b0;
    div_a = {DW{1'b0}};
    div_b = {DW{1'b0}};
    if (accept && !ptr_bad && op_code == `AMU_OP_BCD_DIV) begin
        div_a = {20'h00000, acc_bin};
        div_b = {20'h00000, dsr_bin};
        div_go = (op_src != `AMU_SRC_CONST) && bcd_ok(acc_q) && bcd_ok(pair) && (pair != 32'h00000000);
    end else if (accept && !ptr_bad && op_code == `AMU_OP_REAL_DIV) begin
        // Scaled so the quotient keeps 26 to 27 significant bits
        div_a = {2'b00, man_a, 26'h0000000};
        div_b = {28'h0000000, man_b};
        div_go = !non_real(acc_q) && !non_real(pair) && !a_zero && !b_zero;
    end
end
// Real quotient normalisation; fraction is truncated, not rounded
wire lead = div_q[26];
wire [9:0] e_res = ebase_q + {9'h000, lead};
wire [22:0] frac = lead ? div_q[25:3] : div_q[24:2];
wire e_under = e_res[9] || (e_res == 10'h000);
wire e_over = !e_res[9] && (e_res >= `AMU_FLT_EXP_TOP);
// ----------------------------------------------------------------
// Operation sequencer
// ----------------------------------------------------------------
always @(posedge core_clk) begin
    if (rst) begin
        state_q <= `AMU_ST_IDLE;
        mode_q <= `AMU_MODE_BCD;
        sign_q <= 1'b0;
        ebase_q <= 10'h000;
        busy_q <= 1'b0;
        done_q <= 1'b0;
        src_rejected_q <= 1'b0;
        acc_q <= `AMU_ACC_RST;
        stack1_q <= `AMU_ACC_RST;
        mem_wdata_q <= 16'h0000;
        mem_we_q <= 1'b0;
        operand_too_large_flag <= 1'b0;
        zero_result_flag <= 1'b0;
        negative_result_flag <= 1'b0;
        bad_pointer_flag <= 1'b0;
        float_validity_flag <= 1'b0;
        signed_overflow_flag <= 1'b0;
        float_underflow_flag <= 1'b0;
        illegal_digit_flag <= 1'b0;
        carry16_flag <= 1'b0;
        carry32_flag <= 1'b0;
    end else begin
        done_q <= 1'b0;
        mem_we_q <= 1'b0;
        src_rejected_q <= 1'b0;
        // Flags untouched by an op keep value
        case (state_q)
        `AMU_ST_IDLE: begin
            if (accept) begin
                done_q <= !div_go;
                if (!div_go)
                    bad_pointer_flag <= ptr_bad;
                if (div_go) begin
                    // Hold off new ops until divide ends
                    state_q <= `AMU_ST_WAIT;
                    busy_q <= 1'b1;
                    mode_q <= (op_code == `AMU_OP_REAL_DIV);
                    sign_q <= sign_ab;
                    ebase_q <= ebase;
                end else if (!ptr_bad) begin
                    case (op_code)
                    `AMU_OP_BCD_DIV: begin
                        if (op_src == `AMU_SRC_CONST) begin
                            src_rejected_q <= 1'b1;
                        end else begin
                            illegal_digit_flag <= !(bcd_ok(acc_q) && bcd_ok(pair));
                            operand_too_large_flag <= bcd_ok(acc_q) && bcd_ok(pair);
                        end
                    end
                    `AMU_OP_REAL_DIV: begin
                        illegal_digit_flag <= non_real(acc_q) || non_real(pair);
                        if (!non_real(acc_q) && !non_real(pair)) begin
                            float_underflow_flag <= 1'b0;
                            signed_overflow_flag <= 1'b0;
                            negative_result_flag <= !a_zero && sign_ab;
                            zero_result_flag <= a_zero;
                            // Nonzero divided by zero leaves infinity, not a valid float
                            float_validity_flag <= a_zero;
                            acc_q <= a_zero ? {sign_ab, 31'h00000000} : {sign_ab, `AMU_FLT_EXP_ALL, 23'h000000};
                        end else begin
                            float_validity_flag <= !non_real(acc_q);
                        end
                    end
                    `AMU_OP_BCD_INC,
                    `AMU_OP_BCD_DEC: begin
                        illegal_digit_flag <= !bcd_ok({16'h0000, opnd_lo});
                        if (bcd_ok({16'h0000, opnd_lo})) begin
                            mem_we_q <= 1'b1;
                            if (op_code == `AMU_OP_BCD_INC) begin
                                // Add one, wrap 9999 to 0
                                mem_wdata_q <= inc_bcd[15:0];
                                zero_result_flag <= (inc_bin == 32'h00000000);
                            end else begin
                                // Subtract one, wrap 0 to 9999
                                mem_wdata_q <= dec_bcd[15:0];
                                zero_result_flag <= (dec_bin == 32'h00000000);
                            end
                        end
                    end
                    `AMU_OP_BIN_ADD: begin
                        acc_q <= sum33[31:0];
                        carry16_flag <= sum17[16];
                        carry32_flag <= sum33[32];
                        signed_overflow_flag <= !acc_q[31] && sum33[31];
                        negative_result_flag <= sum33[31];
                        zero_result_flag <= (sum33[31:0] == 32'h00000000);
                    end
                    default: begin
                        src_rejected_q <= 1'b1;
                    end
                    endcase
                end
            end else if (acc_load) begin
                acc_q <= acc_load_val;
            end
        end
        `AMU_ST_WAIT: begin
            if (div_done) begin
                state_q <= `AMU_ST_IDLE;
                busy_q <= 1'b0;
                done_q <= 1'b1;
                bad_pointer_flag <= 1'b0;
                illegal_digit_flag <= 1'b0;
                operand_too_large_flag <= 1'b0;
                if (mode_q == `AMU_MODE_BCD) begin
                    acc_q <= bin_to_bcd(div_q[31:0]);
                    stack1_q <= bin_to_bcd(div_r[31:0]);
                    zero_result_flag <= (div_q[31:0] == 32'h00000000);
                    negative_result_flag <= 1'b0;
                end else if (e_under) begin
                    float_underflow_flag <= 1'b1;
                    signed_overflow_flag <= 1'b0;
                    acc_q <= {sign_q, 31'h00000000};
                    zero_result_flag <= 1'b1;
                    negative_result_flag <= 1'b0;
                    float_validity_flag <= 1'b1;
                end else begin
                    float_underflow_flag <= 1'b0;
                    signed_overflow_flag <= e_over;
                    float_validity_flag <= !e_over;
                    acc_q <= e_over ? {sign_q, `AMU_FLT_EXP_ALL, 23'h000000} : {sign_q, e_res[7:0], frac};
                    zero_result_flag <= 1'b0;
                    negative_result_flag <= sign_q;
                end
            end
        end
        default: begin
            state_q <= `AMU_ST_IDLE;
            busy_q <= 1'b0;
        end
        endcase
    end
end
endmodule // amu_math_unit

// [logic/amu_defs.vh]
/*
 Constants for the accumulator math unit: operation and source codes,
 state codes, reset values and number-format constants.
 Assumes it is included by bare name from the design files.
*/
`ifndef AMU_DEFS_VH
`define AMU_DEFS_VH

// ----------------------------------------------------------------
// Operation codes on op_code
// ----------------------------------------------------------------
`define AMU_OP_BCD_DIV 3'h0
`define AMU_OP_REAL_DIV 3'h1
`define AMU_OP_BCD_INC 3'h2
`define AMU_OP_BCD_DEC 3'h3
`define AMU_OP_BIN_ADD 3'h4

// ----------------------------------------------------------------
// Operand source codes on op_src
// ----------------------------------------------------------------
`define AMU_SRC_CONST 2'h0
`define AMU_SRC_DIRECT 2'h1
`define AMU_SRC_PTR 2'h2

// ----------------------------------------------------------------
// Sequencer states and divide modes
// ----------------------------------------------------------------
`define AMU_ST_IDLE 1'b0
`define AMU_ST_WAIT 1'b1
`define AMU_MODE_BCD 1'b0
`define AMU_MODE_REAL 1'b1

// ----------------------------------------------------------------
// Widths, reset values, number formats
// ----------------------------------------------------------------
`define AMU_DIV_W 52
`define AMU_ACC_RST 32'h00000000
`define AMU_WORD_MAX_BIN 32'h0000270f
`define AMU_FLT_QNAN 32'h7fc00000
`define AMU_FLT_EXP_ALL 8'hff
`define AMU_FLT_BIAS_M1 10'h07e
`define AMU_FLT_EXP_TOP 10'h0ff

`endif

// [logic/amu_seq_divider.v]
/*
 Iterative restoring unsigned divider, one quotient bit per clock.
 Assumes start is offered only while busy is low and divisor is nonzero.
*/
`timescale 1ns/1ns

module amu_seq_divider #(
    parameter W = 52
) (
    input wire core_clk,
    input wire rst,
    input wire start,
    input wire [W-1:0] dividend,
    input wire [W-1:0] divisor,
    output reg busy,
    output reg done,
    output reg [W-1:0] quotient,
    output reg [W-1:0] remainder
);

localparam CW = $clog2(W + 1);

reg [W-1:0] dsr_q;
reg [CW-1:0] cnt_q;
wire [W:0] trial = {remainder, quotient[W-1]};
wire fits = (trial >= {1'b0, dsr_q});
wire [W:0] diff = trial - {1'b0, dsr_q};

always @(posedge core_clk) begin
    if (rst) begin
        busy <= 1'b0;
        done <= 1'b0;
        quotient <= {W{1'b0}};
        remainder <= {W{1'b0}};
        dsr_q <= {W{1'b0}};
        cnt_q <= {CW{1'b0}};
    end else begin
        done <= 1'b0;
        if (start && !busy) begin
            remainder <= {W{1'b0}};
            quotient <= dividend;
            dsr_q <= divisor;
            cnt_q <= W[CW-1:0];
            busy <= 1'b1;
        end else if (busy) begin
            remainder <= fits ? diff[W-1:0] : trial[W-1:0];
            quotient <= {quotient[W-2:0], fits};
            cnt_q <= cnt_q - {{(CW-1){1'b0}}, 1'b1};
            if (cnt_q == {{(CW-1){1'b0}}, 1'b1}) begin
                busy <= 1'b0;
                done <= 1'b1;
            end
        end
    end
end

endmodule // amu_seq_divider

// [test/amu_chk.sv]
/*
 Port-level checker for the accumulator math unit.
 Assumes one clock domain, synchronous active-high reset, bound by name.
*/
`timescale 1ns/1ns
module amu_chk (
    input wire core_clk,
    input wire rst,
    input wire op_start,
    input wire [2:0] op_code,
    input wire [1:0] op_src,
    input wire [15:0] opnd_lo,
    input wire ptr_valid,
    input wire acc_load,
    input wire busy_q,
    input wire done_q,
    input wire src_rejected_q,
    input wire [31:0] acc_q,
    input wire [31:0] stack1_q,
    input wire mem_we_q,
    input wire zero_result_flag,
    input wire negative_result_flag,
    input wire bad_pointer_flag,
    input wire carry16_flag
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    wire take = op_start && !busy_q && (op_src != 2'h2 || ptr_valid);
    wire add_go = take && op_code == 3'h4;
    wire idle_go = op_start && !busy_q;
    // -------------------------------------------------------
    // Completion timing
    // -------------------------------------------------------
    chk_we_done: assert property (mem_we_q |-> done_q && !busy_q)
        else $error("write strobe outside completion");
    chk_div_time: assert property ($rose(busy_q) |-> ##53 (done_q && !busy_q))
        else $error("divide done late or early");
    // Flags move only on completion, the accumulator also on acc_load
    chk_flag_hold: assert property (!done_q |->
        $stable({zero_result_flag, negative_result_flag, bad_pointer_flag, carry16_flag}))
        else $error("flag moved without completion");
    chk_acc_hold: assert property (!done_q && !$past(acc_load) |-> $stable(acc_q) && $stable(stack1_q))
        else $error("accumulator moved without completion");
    // -------------------------------------------------------
    // Binary add
    // -------------------------------------------------------
    chk_add_sum: assert property (add_go |=> done_q && acc_q == $past(acc_q) + {16'h0, $past(opnd_lo)})
        else $error("binary sum wrong");
    chk_add_flags: assert property (add_go |=>
        zero_result_flag == (acc_q == 32'h0) && negative_result_flag == acc_q[31])
        else $error("zero or negative flag wrong");
    chk_carry_low: assert property (add_go |=>
        carry16_flag == ($past(acc_q[15:0]) > 16'hffff - $past(opnd_lo)))
        else $error("low carry wrong");
    // -------------------------------------------------------
    // Refusals
    // -------------------------------------------------------
    chk_const_rej: assert property (idle_go && op_code == 3'h0 && op_src == 2'h0 |=>
        src_rejected_q && $stable(acc_q))
        else $error("constant divisor accepted");
    chk_bad_ptr: assert property (idle_go && op_src == 2'h2 && !ptr_valid |=>
        done_q && bad_pointer_flag && $stable(acc_q))
        else $error("bad pointer not flagged");
    cov_divide: cover property ($rose(busy_q));
    cov_reject: cover property (src_rejected_q);
    cov_write: cover property (mem_we_q);
endmodule // amu_chk

bind amu_math_unit amu_chk i_amu_chk (.core_clk(core_clk), .rst(rst), .op_start(op_start),
    .op_code(op_code), .op_src(op_src), .opnd_lo(opnd_lo), .ptr_valid(ptr_valid), .acc_load(acc_load),
    .busy_q(busy_q), .done_q(done_q), .src_rejected_q(src_rejected_q), .acc_q(acc_q), .stack1_q(stack1_q),
    .mem_we_q(mem_we_q), .zero_result_flag(zero_result_flag), .negative_result_flag(negative_result_flag),
    .bad_pointer_flag(bad_pointer_flag), .carry16_flag(carry16_flag));

// [test/amu_mem_model.sv]
/*
 Operand memory of the instruction sequencer: word pairs out, write-back in.
 Assumes the bench holds addr from op start until the write has landed.
*/
`timescale 1ns/1ns
module amu_mem_model (
    input wire core_clk,
    input wire [4:0] addr,
    input wire [15:0] mem_wdata_q,
    input wire mem_we_q,
    output wire [15:0] word_lo,
    output wire [15:0] word_hi,
    output wire ptr_ok
);
    reg [15:0] mem [0:15];
    // pointer range: the whole pair must exist
    assign ptr_ok = addr < 5'h0f;
    // Nonexistent words read as a mangled pattern, never a stale value
    assign word_lo = ptr_ok ? mem[addr[3:0]] : ~mem[0];
    assign word_hi = ptr_ok ? mem[addr[3:0] + 4'h1] : mem[0] ^ 16'ha5a5;
    always @(posedge core_clk) begin
        if (mem_we_q)
            mem[addr[3:0]] <= mem_wdata_q;
    end
endmodule // amu_mem_model

// [test/amu_math_unit_tb.sv]
/*
 Self-checking bench for the accumulator math unit with a memory model.
 Assumes one-cycle ops and 54-cycle divides behind a sync active-high reset.
*/
`timescale 1ns/1ns
module amu_math_unit_tb;
    reg core_clk = 0;
    reg rst = 1;
    reg op_start = 0;
    reg acc_load = 0;
    reg [2:0] op_code = 0;
    reg [1:0] op_src = 0;
    reg [4:0] addr = 0;
    reg [31:0] acc_load_val = 0;
    reg [15:0] lfsr = 16'h5c44;
    integer mismatches = 0;
    integer checks = 0;
    integer i, e;
    reg [32:0] s;
    reg [16:0] t;
    reg [31:0] a, ew;
    reg [15:0] b;
    reg rj;
    reg [31:0] exp_q [$];
    wire [15:0] w_lo, w_hi, mem_wdata_q;
    wire [31:0] acc_q, stack1_q;
    wire ptr_ok, busy_q, done_q, rej, mem_we_q, tbf, zf, nf, bpf, fvf, ovf, uf, idf, c16, c32;
    logic [31:0] ba [5] = '{32'h12345678, 32'h00000007, 32'h00001234, 32'h0000123a, 32'h00000005};
    logic [31:0] bd [5] = '{32'h00000123, 32'h00010000, 32'h00000000, 32'h00000001, 32'h00000001};
    logic [31:0] ra [7] = '{32'h40c00000, 32'hc0c00000, 32'h00800000, 32'h7f000000, 32'h40000000,
        32'h40000000, 32'h00000000};
    logic [31:0] rd [7] = '{32'h40000000, 32'h40000000, 32'h7f000000, 32'h00800000, 32'h7fc00000,
        32'h00000000, 32'h40000000};
    logic [31:0] re [7] = '{32'h40400000, 32'hc0400000, 32'h00000000, 32'h7f800000, 32'h40000000,
        32'h7f800000, 32'h00000000};
    logic [5:0] rf [7] = '{6'h08, 6'h09, 6'h2a, 6'h10, 6'h0c, 6'h00, 6'h0a};
    logic [15:0] iw [4] = '{16'h0099, 16'h9999, 16'h0000, 16'h00a0};

    amu_math_unit i_amu_math_unit (.core_clk(core_clk), .rst(rst), .op_start(op_start), .op_code(op_code),
        .op_src(op_src), .opnd_lo(w_lo), .opnd_hi(w_hi), .ptr_valid(ptr_ok), .acc_load(acc_load),
        .acc_load_val(acc_load_val), .busy_q(busy_q), .done_q(done_q), .src_rejected_q(rej), .acc_q(acc_q),
        .stack1_q(stack1_q), .mem_wdata_q(mem_wdata_q), .mem_we_q(mem_we_q), .operand_too_large_flag(tbf),
        .zero_result_flag(zf), .negative_result_flag(nf), .bad_pointer_flag(bpf), .float_validity_flag(fvf),
        .signed_overflow_flag(ovf), .float_underflow_flag(uf), .illegal_digit_flag(idf),
        .carry16_flag(c16), .carry32_flag(c32));
    amu_mem_model i_amu_mem_model (.core_clk(core_clk), .addr(addr), .mem_wdata_q(mem_wdata_q),
        .mem_we_q(mem_we_q), .word_lo(w_lo), .word_hi(w_hi), .ptr_ok(ptr_ok));

    always #50 core_clk = ~core_clk;

    // -------------------------------------------------------
    // Helpers
    // -------------------------------------------------------
    function [15:0] nx(input [15:0] v);
        nx = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    function integer b2i(input [31:0] v);
        integer k;
        begin
            b2i = 0;
            for (k = 7; k >= 0; k = k - 1)
                b2i = b2i * 10 + v[k*4 +: 4];
        end
    endfunction
    function [31:0] i2b(input integer x);
        integer k;
        begin
            for (k = 0; k < 8; k = k + 1) begin
                i2b[k*4 +: 4] = x % 10;
                x = x / 10;
            end
        end
    endfunction
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            checks = checks + 1;
            if (seen !== exp) begin
                mismatches = mismatches + 1;
                $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task ld(input [31:0] v);
        begin
            acc_load_val = v;
            acc_load = 1;
            @(posedge core_clk);
            #1 acc_load = 0;
        end
    endtask
    task run(input [2:0] c, input [1:0] src, input [4:0] ad);
        integer n;
        begin
            op_code = c;
            op_src = src;
            addr = ad;
            op_start = 1;
            @(posedge core_clk);
            #1 op_start = 0;
            n = 0;
            while (done_q !== 1'b1 && n < 80) begin
                @(posedge core_clk);
                #1 n = n + 1;
            end
            rj = rej;
            chk(n < 80, 1);
            @(posedge core_clk);
            #1;
        end
    endtask
    task final_report;
        begin
            $display("checks %0d mismatches %0d", checks, mismatches);
            if (mismatches == 0 && checks > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask

    initial begin
        #400000;
        mismatches = mismatches + 1;
        final_report;
    end

    // -------------------------------------------------------
    // Main sequence
    // -------------------------------------------------------
    initial begin
        repeat (10) @(posedge core_clk);
        #1 rst = 0;
        chk(acc_q, 0);
        chk(stack1_q, 0);
        chk({tbf, zf, nf, bpf, fvf, ovf, uf, idf, c16, c32}, 0);
        chk({busy_q, done_q, rej, mem_we_q, mem_wdata_q}, 0);
        // Binary add: random, then wrap to zero, then signed overflow
        for (i = 0; i < 8; i = i + 1) begin
            lfsr = nx(lfsr);
            a = {lfsr, nx(lfsr)};
            lfsr = nx(nx(lfsr));
            b = lfsr;
            if (i == 6) a = 32'hffffffff;
            if (i > 5) b = 16'h0001;
            if (i == 7) a = 32'h7fffffff;
            ld(a);
            i_amu_mem_model.mem[0] = b;
            run(3'h4, {1'b0, i[0]}, 5'd0);
            s = {1'b0, a} + {17'h0, b};
            t = {1'b0, a[15:0]} + {1'b0, b};
            exp_q.push_back(s[31:0]);
            chk(acc_q, exp_q.pop_front());
            chk({c16, c32}, {t[16], s[32]});
            chk({ovf, nf, zf}, {!a[31] && s[31], s[31], s[31:0] == 0});
        end
        // BCD increment and decrement of a memory word
        for (i = 0; i < 4; i = i + 1) begin
            i_amu_mem_model.mem[2] = iw[i];
            run(i < 2 ? 3'h2 : 3'h3, 2'h2, 5'd2);
            e = (b2i({16'h0, iw[i]}) + (i < 2 ? 1 : 9999)) % 10000;
            ew = (i == 3) ? {16'h0, iw[i]} : i2b(e);
            chk(i_amu_mem_model.mem[2], ew);
            chk(idf, i == 3);
            if (i < 3) chk(zf, ew == 0);
            chk({nf, ovf}, 2'h3);
        end
        // BCD divide: normal, pointer source, zero, bad digit, constant
        for (i = 0; i < 5; i = i + 1) begin
            ld(ba[i]);
            i_amu_mem_model.mem[4] = bd[i][15:0];
            i_amu_mem_model.mem[5] = bd[i][31:16];
            run(3'h0, i == 4 ? 2'h0 : (i == 1 ? 2'h2 : 2'h1), 5'd4);
            if (i < 2) begin
                chk(acc_q, i2b(b2i(ba[i]) / b2i(bd[i])));
                chk(stack1_q, i2b(b2i(ba[i]) % b2i(bd[i])));
                chk({zf, nf}, {b2i(ba[i]) < b2i(bd[i]), 1'b0});
            end else
                chk(acc_q, ba[i]);
            chk({tbf, idf, rj}, {i == 2, i >= 3, i == 4});
        end
        // Real divide: pointer to nowhere first, then the value table
        ld(32'h40000000);
        run(3'h1, 2'h2, 5'd20);
        chk(acc_q, 32'h40000000);
        chk(bpf, 1);
        for (i = 0; i < 7; i = i + 1) begin
            ld(ra[i]);
            i_amu_mem_model.mem[6] = rd[i][15:0];
            i_amu_mem_model.mem[7] = rd[i][31:16];
            run(3'h1, i == 0 ? 2'h0 : 2'h1, 5'd6);
            chk(acc_q, re[i]);
            chk({uf, ovf, fvf, idf, zf, nf} & (i == 4 ? 6'h0c : 6'h3f), rf[i]);
            chk(bpf, 0);
        end
        // Unknown operation code is refused
        run(3'h5, 2'h1, 5'd6);
        chk({rj, bpf}, 2'h2);
        final_report;
    end
endmodule // amu_math_unit_tb
